// File: include/dab_pkg.sv
// ****************************************************************
// dual pipelined converter back end: shared constants
// ****************************************************************
package dab_pkg;

  // ****************************************************************
  // widths and structure
  // ****************************************************************
  localparam int CHANNELS  = 2;
  localparam int CH_I      = 0;
  localparam int CH_Q      = 1;
  localparam int WORD_W    = 10;
  localparam int IN_W      = 12;
  localparam int RES_W     = 16;
  localparam int CODE_W    = 2;
  localparam int STAGES    = 8;
  localparam int PAIRS     = 4;
  localparam int PAIR_BITS = 4;
  localparam int CODES_W   = 16;
  localparam int ALIGNED_W = 18;
  localparam int BUF_W     = 20;

  // ****************************************************************
  // residue scale: full scale of +/-0.5 V maps to +/-RES_FULL
  // ****************************************************************
  localparam logic signed [RES_W-1:0] RES_FULL = 16'sh2000;
  localparam logic signed [RES_W-1:0] RES_HALF = 16'sh1000;
  localparam logic signed [RES_W-1:0] RES_QTR  = 16'sh0800;
  localparam logic signed [RES_W-1:0] RES_ZERO = 16'sh0000;

  // ****************************************************************
  // stage decision codes (one redundant level) and plain ninth-stage flash codes
  // ****************************************************************
  localparam logic [CODE_W-1:0] CODE_NEG = 2'h0;
  localparam logic [CODE_W-1:0] CODE_MID = 2'h1;
  localparam logic [CODE_W-1:0] CODE_POS = 2'h2;
  localparam logic [CODE_W-1:0] FLASH_0  = 2'h0;
  localparam logic [CODE_W-1:0] FLASH_1  = 2'h1;
  localparam logic [CODE_W-1:0] FLASH_2  = 2'h2;
  localparam logic [CODE_W-1:0] FLASH_3  = 2'h3;

  // ****************************************************************
  // output coding and correction arithmetic
  // ****************************************************************
  localparam logic [WORD_W-1:0] WORD_MIN   = 10'h000;
  localparam logic [WORD_W-1:0] WORD_MAX   = 10'h3ff;
  localparam int                WORD_TOP   = 1023;
  localparam int                WORD_BOT   = 0;
  // stage codes at mid level plus flash level two already sum to half
  // scale, so the overlapping add needs no further bias
  localparam int                CORR_BIAS  = 0;
  localparam int                MSB_WEIGHT = 8;

  // ****************************************************************
  // timing, in master clock cycles (10 MHz, 100 ns period)
  // ****************************************************************
  localparam int CLK_PERIOD_NS        = 100;
  localparam int LATENCY_CYCLES       = 6;
  localparam int INIT_INVALID_CYCLES  = 20;
  localparam int FILL_W               = 5;
  localparam logic [FILL_W-1:0] FILL_LAST = 5'h13;
  localparam logic [FILL_W-1:0] FILL_ZERO = 5'h00;
  localparam logic [FILL_W-1:0] FILL_ONE  = 5'h01;

  // ****************************************************************
  // start-up sequencing
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_HOLD = 3'h1,
    ST_FILL = 3'h2,
    ST_RUN  = 3'h4
  } dab_fill_t;

endpackage

// File: hw/dab_buf.sv
`timescale 1ns/1ps
// two-entry buffer: an output slot plus one spare slot, so a
// receiver stall of one cycle drops no word while the spare slot is empty; under a steady
// source the backlog then stays one word deep (one extra cycle)
module dab_buf #(
  parameter int W = 20
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);

  logic         out_valid;
  logic [W-1:0] out_data;
  logic         spare_valid;
  logic [W-1:0] spare_data;
  logic         out_free;

  // out slot empties when empty or taken this cycle
  assign out_free = !out_valid || i_ready;
  // refuse only when both slots stay occupied through this edge
  assign o_ready  = !spare_valid || out_free;
  assign o_valid  = out_valid;
  assign o_data   = out_data;

  // output slot
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (out_free) begin
      if (spare_valid) begin
        out_valid <= 1'b1;
        out_data  <= spare_data;
      end else begin
        out_valid <= i_valid;
        if (i_valid) begin
          out_data <= i_data;
        end
      end
    end
  end

  // spare slot catches a word while the output is stalled
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      spare_valid <= 1'b0;
      spare_data  <= '0;
    end else if (out_free) begin
      // spare moves up and refills at once, so a backlog keeps pace
      spare_valid <= spare_valid && i_valid;
      if (spare_valid && i_valid) begin
        spare_data <= i_data;
      end
    end else if (i_valid && !spare_valid) begin
      spare_valid <= 1'b1;
      spare_data  <= i_data;
    end
  end

endmodule

// File: hw/dab_adc_backend.sv
`timescale 1ns/1ps
// How it works
// - two independent 10-bit channels, I and Q, run from the one master clock.
// - two non-overlapping phases come from the master clock; the sample is taken as the sampling phase ends.
// - each channel has eight identical two-bit stages followed by a two-bit flash ninth stage.
// - each stage runs half a cycle behind the one before, so neighbours alternate sampling and amplifying.
// - each of the eight stages delivers two bits, one of them redundant for later correction.
// - a delay line on the sampling clock aligns all stage codes of a sample with the ninth code as 18 bits.
// - correction uses the redundant bits of the 18-bit word to give one corrected 10-bit result per sample.
// - each channel presents a ten-bit parallel word, bit 9 most significant, bit 0 least.
// - the word for a sample appears after the sixth master clock following the sampling clock.
// - after that latency a new word for each successive sample follows every clock; a stall with both buffer slots full drops a word.
// - codes are offset binary, 1000000000 just above zero and 0111111111 just below.
// - near +0.5 V gives all ones, near -0.5 V all zeros, and codes rise monotonically between.
// - words in the first 20 cycles after start are invalid and the receiver drops them.
module dab_adc_backend (
  input  wire logic                       i_clk,
  input  wire logic                       i_rstn,
  input  wire logic [dab_pkg::IN_W-1:0]   i_diff_input_pos_i,
  input  wire logic [dab_pkg::IN_W-1:0]   i_diff_input_neg_i,
  input  wire logic [dab_pkg::IN_W-1:0]   i_diff_input_pos_q,
  input  wire logic [dab_pkg::IN_W-1:0]   i_diff_input_neg_q,
  input  wire logic                       i_ready,
  output logic [dab_pkg::WORD_W-1:0]      o_sample_word_i,
  output logic [dab_pkg::WORD_W-1:0]      o_sample_word_q,
  output logic                            o_valid,
  output logic                            o_overrun
);

  // ****************************************************************
  // functions
  // ****************************************************************

  // differential input scaled into the residue range
  function automatic logic signed [dab_pkg::RES_W-1:0] to_residue(
    input logic [dab_pkg::IN_W-1:0] pos,
    input logic [dab_pkg::IN_W-1:0] neg
  );
    logic signed [dab_pkg::RES_W-1:0] p;
    logic signed [dab_pkg::RES_W-1:0] n;
    p = {{(dab_pkg::RES_W-dab_pkg::IN_W){1'b0}}, pos};
    n = {{(dab_pkg::RES_W-dab_pkg::IN_W){1'b0}}, neg};
    to_residue = (p - n) <<< 1;
  endfunction

  // two-bit stage decision with one redundant level
  function automatic logic [dab_pkg::CODE_W-1:0] stage_code(
    input logic signed [dab_pkg::RES_W-1:0] v
  );
    if (v > dab_pkg::RES_QTR) begin
      stage_code = dab_pkg::CODE_POS;
    end else if (v < -dab_pkg::RES_QTR) begin
      stage_code = dab_pkg::CODE_NEG;
    end else begin
      stage_code = dab_pkg::CODE_MID;
    end
  endfunction

  // gain-of-two residue after subtracting the stage decision
  function automatic logic signed [dab_pkg::RES_W-1:0] stage_residue(
    input logic signed [dab_pkg::RES_W-1:0] v,
    input logic [dab_pkg::CODE_W-1:0]       code
  );
    logic signed [dab_pkg::RES_W-1:0] dbl;
    dbl = v <<< 1;
    case (code)
      dab_pkg::CODE_POS: stage_residue = dbl - dab_pkg::RES_FULL;
      dab_pkg::CODE_NEG: stage_residue = dbl + dab_pkg::RES_FULL;
      default:           stage_residue = dbl;
    endcase
  endfunction

  // ninth stage: plain two-bit flash, no redundancy
  function automatic logic [dab_pkg::CODE_W-1:0] flash_code(
    input logic signed [dab_pkg::RES_W-1:0] v
  );
    if (v >= dab_pkg::RES_HALF) begin
      flash_code = dab_pkg::FLASH_3;
    end else if (v >= dab_pkg::RES_ZERO) begin
      flash_code = dab_pkg::FLASH_2;
    end else if (v >= -dab_pkg::RES_HALF) begin
      flash_code = dab_pkg::FLASH_1;
    end else begin
      flash_code = dab_pkg::FLASH_0;
    end
  endfunction

  // overlapping add of the aligned codes; the overlap absorbs
  // any stage decision error within a quarter of full scale
  function automatic logic [dab_pkg::WORD_W-1:0] correct(
    input logic [dab_pkg::ALIGNED_W-1:0] aligned
  );
    int acc;
    acc = int'(aligned[dab_pkg::CODES_W +: dab_pkg::CODE_W]) - dab_pkg::CORR_BIAS;
    for (int k = 0; k < dab_pkg::STAGES; k++) begin
      acc = acc + (int'(aligned[k*dab_pkg::CODE_W +: dab_pkg::CODE_W]) << (dab_pkg::MSB_WEIGHT - k));
    end
    // clamp keeps the extremes at all zeros and all ones
    if (acc < dab_pkg::WORD_BOT) begin
      correct = dab_pkg::WORD_MIN;
    end else if (acc > dab_pkg::WORD_TOP) begin
      correct = dab_pkg::WORD_MAX;
    end else begin
      correct = acc[dab_pkg::WORD_W-1:0];
    end
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic                                rst_meta;
  logic                                rst_n;
  dab_pkg::dab_fill_t                  fill_state;
  dab_pkg::dab_fill_t                  next_fill_state;
  logic [dab_pkg::FILL_W-1:0]          fill_count;
  logic [dab_pkg::IN_W-1:0]            in_pos   [dab_pkg::CHANNELS];
  logic [dab_pkg::IN_W-1:0]            in_neg   [dab_pkg::CHANNELS];
  logic signed [dab_pkg::RES_W-1:0]    held     [dab_pkg::CHANNELS];
  logic signed [dab_pkg::RES_W-1:0]    residue  [dab_pkg::CHANNELS][dab_pkg::PAIRS];
  logic signed [dab_pkg::RES_W-1:0]    next_residue [dab_pkg::CHANNELS][dab_pkg::PAIRS];
  logic [dab_pkg::CODES_W-1:0]         dly      [dab_pkg::CHANNELS][dab_pkg::PAIRS];
  logic [dab_pkg::CODES_W-1:0]         next_dly [dab_pkg::CHANNELS][dab_pkg::PAIRS];
  logic [dab_pkg::ALIGNED_W-1:0]       aligned  [dab_pkg::CHANNELS];
  logic [dab_pkg::WORD_W-1:0]          corr     [dab_pkg::CHANNELS];
  logic                                corr_valid;
  logic                                buf_ready;
  logic                                buf_valid;
  logic [dab_pkg::BUF_W-1:0]           buf_data;

  // ****************************************************************
  // reset release
  // ****************************************************************

  // two flops so the release never lands mid-cycle on the pipeline
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************************************
  // input mapping
  // ****************************************************************

  assign in_pos[dab_pkg::CH_I] = i_diff_input_pos_i;
  assign in_neg[dab_pkg::CH_I] = i_diff_input_neg_i;
  assign in_pos[dab_pkg::CH_Q] = i_diff_input_pos_q;
  assign in_neg[dab_pkg::CH_Q] = i_diff_input_neg_q;

  // ****************************************************************
  // sample and hold
  // ****************************************************************

  // capture at phase end
  // the rising master edge stands for the end of the sampling phase;
  // the hold phase is the following clock high time
  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      for (int ch = 0; ch < dab_pkg::CHANNELS; ch++) begin
        held[ch] <= dab_pkg::RES_ZERO;
      end
    end else begin
      for (int ch = 0; ch < dab_pkg::CHANNELS; ch++) begin
        held[ch] <= to_residue(in_pos[ch], in_neg[ch]);
      end
    end
  end

  // ****************************************************************
  // stage pipeline
  // ****************************************************************

  // alternate stage phases
  // stages go in pairs: the odd stage amplifies in one phase and
  // the even stage in the other, so one pair settles per master
  // cycle; this is why the whole chain fits in four registers
  always_comb begin
    logic signed [dab_pkg::RES_W-1:0] src;
    logic signed [dab_pkg::RES_W-1:0] mid;
    logic [dab_pkg::CODE_W-1:0]       c_odd;
    logic [dab_pkg::CODE_W-1:0]       c_even;
    logic [dab_pkg::CODES_W-1:0]      base;
    src    = dab_pkg::RES_ZERO;
    mid    = dab_pkg::RES_ZERO;
    c_odd  = dab_pkg::CODE_MID;
    c_even = dab_pkg::CODE_MID;
    base   = '0;
    for (int ch = 0; ch < dab_pkg::CHANNELS; ch++) begin
      for (int p = 0; p < dab_pkg::PAIRS; p++) begin
        if (p == 0) begin
          src  = held[ch];
          base = '0;
        end else begin
          src  = residue[ch][p-1];
          base = dly[ch][p-1];
        end
        c_odd  = stage_code(src);
        mid    = stage_residue(src, c_odd);
        c_even = stage_code(mid);
        base[p*dab_pkg::PAIR_BITS +: dab_pkg::CODE_W] = c_odd;
        base[p*dab_pkg::PAIR_BITS+dab_pkg::CODE_W +: dab_pkg::CODE_W] = c_even;
        next_residue[ch][p] = stage_residue(mid, c_even);
        next_dly[ch][p]     = base;
      end
    end
  end

  // code delay line
  // earlier codes ride along with later residues, so every code of
  // one sample meets the ninth code in the same cycle
  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      for (int ch = 0; ch < dab_pkg::CHANNELS; ch++) begin
        for (int p = 0; p < dab_pkg::PAIRS; p++) begin
          residue[ch][p] <= dab_pkg::RES_ZERO;
          dly[ch][p]     <= '0;
        end
      end
    end else begin
      for (int ch = 0; ch < dab_pkg::CHANNELS; ch++) begin
        for (int p = 0; p < dab_pkg::PAIRS; p++) begin
          residue[ch][p] <= next_residue[ch][p];
          dly[ch][p]     <= next_dly[ch][p];
        end
      end
    end
  end

  always_comb begin
    for (int ch = 0; ch < dab_pkg::CHANNELS; ch++) begin
      aligned[ch] = {flash_code(residue[ch][dab_pkg::PAIRS-1]), dly[ch][dab_pkg::PAIRS-1]};
    end
  end

  // ****************************************************************
  // error correction
  // ****************************************************************

  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      for (int ch = 0; ch < dab_pkg::CHANNELS; ch++) begin
        corr[ch] <= dab_pkg::WORD_MIN;
      end
    end else begin
      for (int ch = 0; ch < dab_pkg::CHANNELS; ch++) begin
        corr[ch] <= correct(aligned[ch]);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      corr_valid <= 1'b0;
    end else begin
      corr_valid <= (fill_state == dab_pkg::ST_RUN);
    end
  end

  // ****************************************************************
  // start-up sequencing
  // ****************************************************************

  // hold off start-up words
  // twenty cycles covers the six-cycle refill as well, so one
  // counter serves both power-up and reset
  always_comb begin
    case (fill_state)
      dab_pkg::ST_HOLD: next_fill_state = dab_pkg::ST_FILL;
      dab_pkg::ST_FILL: begin
        if (fill_count == dab_pkg::FILL_LAST) begin
          next_fill_state = dab_pkg::ST_RUN;
        end else begin
          next_fill_state = dab_pkg::ST_FILL;
        end
      end
      dab_pkg::ST_RUN:  next_fill_state = dab_pkg::ST_RUN;
      default:          next_fill_state = dab_pkg::ST_HOLD;
    endcase
  end

  // fill state register
  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      fill_state <= dab_pkg::ST_HOLD;
    end else begin
      fill_state <= next_fill_state;
    end
  end

  // fill counter, frozen once running
  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      fill_count <= dab_pkg::FILL_ZERO;
    end else if (fill_state == dab_pkg::ST_FILL) begin
      fill_count <= fill_count + dab_pkg::FILL_ONE;
    end
  end

  // ****************************************************************
  // output buffer
  // ****************************************************************

  // one word per clock
  // the buffer's output slot is the sixth register after sampling
  dab_buf #(
    .W (dab_pkg::BUF_W)
  ) u_buf (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_valid (corr_valid),
    .i_data  ({corr[dab_pkg::CH_I], corr[dab_pkg::CH_Q]}),
    .o_ready (buf_ready),
    .o_valid (buf_valid),
    .o_data  (buf_data),
    .i_ready (i_ready)
  );

  // the converter cannot pause its input, so a word refused by a
  // full buffer is lost; flag it rather than hide it
  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      o_overrun <= 1'b0;
    end else begin
      o_overrun <= corr_valid && !buf_ready;
    end
  end

  assign o_sample_word_i = buf_data[dab_pkg::WORD_W +: dab_pkg::WORD_W];
  assign o_sample_word_q = buf_data[0 +: dab_pkg::WORD_W];
  assign o_valid         = buf_valid;

endmodule

// File: testbench/dab_chk_sva.sv
`timescale 1ns/1ps
// ****************************************************************
// port checker for the converter back end
// ****************************************************************
module dab_chk (
  input wire logic                       i_clk,
  input wire logic                       i_rstn,
  input wire logic [dab_pkg::IN_W-1:0]   i_diff_input_pos_i,
  input wire logic [dab_pkg::IN_W-1:0]   i_diff_input_neg_i,
  input wire logic [dab_pkg::IN_W-1:0]   i_diff_input_pos_q,
  input wire logic [dab_pkg::IN_W-1:0]   i_diff_input_neg_q,
  input wire logic                       i_ready,
  input wire logic [dab_pkg::WORD_W-1:0] o_sample_word_i,
  input wire logic [dab_pkg::WORD_W-1:0] o_sample_word_q,
  input wire logic                       o_valid,
  input wire logic                       o_overrun
);
  int since;
  int run_hi;
  int run_lo;

  // edges since release, and runs of steady full-scale input
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      since  <= 0;
      run_hi <= 0;
      run_lo <= 0;
    end else begin
      since  <= (since < 99) ? since + 1 : since;
      run_hi <= (i_diff_input_pos_i == 12'hfff && i_diff_input_neg_i == 12'h000) ? run_hi + 1 : 0;
      run_lo <= (i_diff_input_pos_q == 12'h000 && i_diff_input_neg_q == 12'hfff) ? run_lo + 1 : 0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // receiver holding off a valid word
  sequence s_stalled;
    o_valid && !i_ready;
  endsequence
  // three edges of free flow leave no edge on which a word can be refused
  sequence s_flowing;
    i_ready [*3];
  endsequence

  a_clear_after_reset: assert property (since <= 1 |-> !o_valid && !o_overrun &&
    o_sample_word_i == 10'h000 && o_sample_word_q == 10'h000) else $error("outputs not clear after reset");
  a_fill_quiet: assert property (since <= 20 |-> !o_valid)
    else $error("valid during start-up fill");
  a_valid_in_time: assert property (since == 40 |-> o_valid)
    else $error("valid late after fill");
  a_valid_steady: assert property (o_valid |=> o_valid)
    else $error("gap in word stream");
  a_word_holds: assert property (s_stalled |=> o_valid && $stable(o_sample_word_i) && $stable(o_sample_word_q))
    else $error("held word changed while stalled");
  a_overrun_cause: assert property (o_overrun |-> !$past(i_ready) || !$past(i_ready, 2))
    else $error("overrun without a stall");
  a_overrun_ends: assert property (s_flowing |=> !o_overrun)
    else $error("overrun while flowing");
  a_full_scale: assert property (s_flowing ##0 (o_valid && run_hi >= 12) |-> o_sample_word_i == 10'h3ff)
    else $error("positive full scale not all ones");
  a_zero_scale: assert property (s_flowing ##0 (o_valid && run_lo >= 12) |-> o_sample_word_q == 10'h000)
    else $error("negative full scale not all zeros");
endmodule

// File: testbench/dab_sink.sv
`timescale 1ns/1ps
// ****************************************************************
// downstream capture model: one word pair per clock
// ****************************************************************
module dab_sink (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_valid,
  input  wire logic i_hold,
  output logic      o_ready,
  output logic      o_take
);
  int warm;

  // ready moves just after a rising edge, never mid-cycle
  initial o_ready = 1'b1;
  always @(posedge i_clk) begin
    o_ready <= !i_hold;
  end

  // edges since reset release
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) warm <= 0;
    else if (warm < 31) warm <= warm + 1;
  end

  assign o_take = i_valid && o_ready && warm >= 20;
endmodule

// File: testbench/dab_adc_backend_tb_top.sv
`timescale 1ns/1ps
// ****************************************************************
// stream bench for the converter back end
// ****************************************************************
module dab_adc_backend_tb_top;
  logic                       i_clk;
  logic                       i_rstn;
  logic                       hold;
  logic                       ready;
  logic                       take;
  logic                       valid;
  logic                       overrun;
  logic [dab_pkg::IN_W-1:0]   pi, ni, pq, nq;
  logic [dab_pkg::WORD_W-1:0] wi, wq;
  int n_errors, checks_done, seed, c, idx, pend, since, n_over, cur_i, cur_q, n0;
  bit aligned;
  int exp_i [0:4095];
  int exp_q [0:4095];
  int table_d [7] = '{4095, -4095, 0, -4, 4, 2044, -2052};

  dab_adc_backend DUT (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_diff_input_pos_i(pi), .i_diff_input_neg_i(ni),
    .i_diff_input_pos_q(pq), .i_diff_input_neg_q(nq), .i_ready(ready),
    .o_sample_word_i(wi), .o_sample_word_q(wq), .o_valid(valid), .o_overrun(overrun));

  dab_sink u_sink (.i_clk(i_clk), .i_rstn(i_rstn), .i_valid(valid), .i_hold(hold), .o_ready(ready), .o_take(take));

  // ideal offset binary code, one step per 8 input counts, floor rounding
  function automatic int code_of(int d);
    int m;
    m = ((d >= 0) ? d / 8 : -((7 - d) / 8)) + 512;
    return (m < 0) ? 0 : (m > 1023) ? 1023 : m;
  endfunction

  // mid-code values keep clear of transition edges
  function automatic int rnd_mid();
    return 8 * ($random(seed) % 512) + 4;
  endfunction

  task automatic split(input int d, output logic [11:0] p, output logic [11:0] n);
    int b;
    b = ($random(seed) & 32'h7fffffff) % (4096 - ((d < 0) ? -d : d));
    p = 12'((d < 0) ? b : b + d);
    n = 12'((d < 0) ? b - d : b);
  endtask

  task automatic put(int di, int dq, bit h);
    @(negedge i_clk);
    cur_i = di;
    cur_q = dq;
    hold = h;
    split(di, pi, ni);
    split(dq, pq, nq);
  endtask

  task automatic run(int n, bit stalls);
    repeat (n) put(rnd_mid(), rnd_mid(), stalls && ($random(seed) % 4 == 0));
  endtask

  task automatic check(string what, int e, logic [9:0] got);
    checks_done++;
    if (got !== 10'(e)) begin
      n_errors++;
      $display("unexpected %s: expected %0d, seen %0d", what, e, got);
    end
  endtask

  task automatic test_end(string name);
    $display("test %s finished", name);
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // reference model: history of ideal codes, matched in sample order;
  // each overrun pulse allows one skipped sample
  always @(posedge i_clk) begin
    int k;
    exp_i[c] = code_of(cur_i);
    exp_q[c] = code_of(cur_q);
    if (!i_rstn) begin
      aligned = 0;
      since = 0;
      pend = 0;
    end else begin
      since++;
      if (overrun) begin
        pend++;
        n_over++;
      end
      if (valid && since <= 20) check("valid during fill", 0, 10'(valid));
      if (take) begin
        if (!aligned) idx = c - 7;
        aligned = 1;
        k = 0;
        while (k < pend && !(wi === 10'(exp_i[idx + k]) && wq === 10'(exp_q[idx + k]))) k++;
        pend -= k;
        idx += k;
        check("word i", exp_i[idx], wi);
        check("word q", exp_q[idx], wq);
        idx++;
      end
    end
    c++;
  end

  initial begin
    #(dab_pkg::CLK_PERIOD_NS * 2000);
    n_errors++;
    $display("watchdog expired");
    close_out();
  end

  initial begin
    seed = 16;
    i_rstn = 1'b0;
    hold = 1'b0;
    {pi, ni, pq, nq} = '0;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    i_rstn = 1'b1;
    run(45, 0);
    test_end("fill");
    foreach (table_d[t]) begin
      repeat (14) put(table_d[t], -table_d[t], 0);
    end
    test_end("codes");
    n0 = n_over;
    put(rnd_mid(), rnd_mid(), 1);
    run(20, 0);
    check("drops after one stall", n0, 10'(n_over));
    test_end("short stall");
    n0 = n_over;
    repeat (6) put(rnd_mid(), rnd_mid(), 1);
    run(20, 0);
    check("long stall drop count in range", 1, 10'(n_over - n0 >= 5 && n_over - n0 <= 7));
    test_end("long stall");
    run(300, 1);
    run(20, 0);
    test_end("random");
    @(negedge i_clk);
    i_rstn = 1'b0;
    repeat (4) begin
      @(negedge i_clk);
      check("valid in reset", 0, 10'(valid));
      check("word in reset", 0, wi);
    end
    i_rstn = 1'b1;
    run(45, 0);
    test_end("second reset");
    close_out();
  end
endmodule

bind dab_adc_backend dab_chk u_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_diff_input_pos_i(i_diff_input_pos_i), .i_diff_input_neg_i(i_diff_input_neg_i),
  .i_diff_input_pos_q(i_diff_input_pos_q), .i_diff_input_neg_q(i_diff_input_neg_q), .i_ready(i_ready),
  .o_sample_word_i(o_sample_word_i), .o_sample_word_q(o_sample_word_q), .o_valid(o_valid), .o_overrun(o_overrun));
